// >>> src/cmpirq_top.sv
/*
 * Comparator output logic: decision with hysteresis, raw output, clock sync,
 * edge flags and gated interrupt request.
 * Assumes the analog inputs arrive as digitised millivolt levels on the clock
 * domain's ports, and software drives the control bits as plain levels.
 */
`timescale 1ns/1ps
module cmpirq_top
	import cmpirq_pkg::*;
#(
	parameter int MV_W = CMPIRQ_MV_W
) (
	// Clock and reset
	input  wire logic            clock_i,
	input  wire logic            resetn_i,
	// Analog inputs as millivolt levels
	input  wire logic [MV_W-1:0] cmp_pos_input_i,
	input  wire logic [MV_W-1:0] cmp_neg_input_i,
	// Control bits
	input  wire logic            cmp_enable_bit_i,
	input  wire logic [1:0]      pos_hyst_sel_i,
	input  wire logic [1:0]      neg_hyst_sel_i,
	input  wire logic [1:0]      response_mode_sel_i,
	input  wire logic            rise_irq_en_i,
	input  wire logic            fall_irq_en_i,
	input  wire logic            rise_flag_clr_i,
	input  wire logic            fall_flag_clr_i,
	input  wire logic            cmp_src_irq_en_i,
	input  wire logic            global_irq_en_i,
	// Outputs
	output logic                 raw_cmp_out_o,
	output logic                 synced_cmp_out_o,
	output logic                 cmp_result_status_o,
	output logic                 rise_edge_flag_o,
	output logic                 fall_edge_flag_o,
	output logic                 irq_o,
	output logic                 shutdown_o,
	output logic [1:0]           analog_mode_o
);

	////////////////////////////////////////////////////////////////////////////
	// Hysteresis code to millivolts

	function automatic logic [MV_W-1:0] hyst_mv(input logic [1:0] sel);
		logic [MV_W-1:0] mv;
		mv = '0;
		unique case (sel)
			CMPIRQ_HYST_OFF:  mv = MV_W'(CMPIRQ_HYST_MV_OFF);
			CMPIRQ_HYST_LVL1: mv = MV_W'(CMPIRQ_HYST_MV_LVL1);
			CMPIRQ_HYST_LVL2: mv = MV_W'(CMPIRQ_HYST_MV_LVL2);
			CMPIRQ_HYST_MAX:  mv = MV_W'(CMPIRQ_HYST_MV_MAX);
		endcase
		return mv;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		logic sync1;
		logic sync2;
		logic prev;
		logic rise;
		logic fall;
	} cmpirq_state_t;

	cmpirq_state_t state_q;
	cmpirq_state_t state_d;
	logic          raw_q;
	logic [MV_W:0] pos_ext;
	logic [MV_W:0] neg_ext;
	logic          raw_set;
	logic          raw_clr;

	////////////////////////////////////////////////////////////////////////////
	// Raw decision, no clock involved; hysteresis held by a level latch

	assign pos_ext = {1'b0, cmp_pos_input_i};
	assign neg_ext = {1'b0, cmp_neg_input_i};

	// Set and clear conditions of the hysteresis memory; they never hold together
	always_comb begin
		raw_set = 1'b0;
		raw_clr = 1'b0;
		if (pos_ext > neg_ext + {1'b0, hyst_mv(pos_hyst_sel_i)})
			raw_set = 1'b1;
		if (pos_ext + {1'b0, hyst_mv(neg_hyst_sel_i)} <= neg_ext)
			raw_clr = 1'b1;
		if (!cmp_enable_bit_i) begin
			raw_set = 1'b0;
			raw_clr = 1'b1;
		end
	end

	// Level latch holds the result between set and clear, so it needs no clock
	// and forms no loop through its own output
	always_latch begin
		if (!resetn_i)
			raw_q <= 1'b0;
		else if (raw_clr)
			raw_q <= 1'b0;
		else if (raw_set)
			raw_q <= 1'b1;
	end

	assign raw_cmp_out_o = raw_q;
	assign shutdown_o    = !cmp_enable_bit_i;
	assign analog_mode_o = response_mode_sel_i;

	////////////////////////////////////////////////////////////////////////////
	// Synchroniser, edge detection and flags

	always_comb begin
		state_d       = state_q;
		state_d.sync1 = raw_q;
		state_d.sync2 = state_q.sync1;
		state_d.prev  = state_q.sync2;
		// Set wins over a clear in the same cycle
		if (rise_flag_clr_i)
			state_d.rise = 1'b0;
		if (fall_flag_clr_i)
			state_d.fall = 1'b0;
		if (state_q.sync2 && !state_q.prev)
			state_d.rise = 1'b1;
		if (!state_q.sync2 && state_q.prev)
			state_d.fall = 1'b1;
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i)
			state_q <= '0;
		else
			state_q <= state_d;
	end

	assign synced_cmp_out_o    = state_q.sync2;
	assign cmp_result_status_o = state_q.sync2;
	assign rise_edge_flag_o    = state_q.rise;
	assign fall_edge_flag_o    = state_q.fall;

	// Request gated per flag, then by source and global enables
	assign irq_o = ((state_q.rise && rise_irq_en_i) || (state_q.fall && fall_irq_en_i))
		&& cmp_src_irq_en_i && global_irq_en_i;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	property p_rise_set;
		@(posedge clock_i) disable iff (!resetn_i)
		(state_q.sync2 && !state_q.prev) |=> rise_edge_flag_o;
	endproperty
	a_rise_set: assert property (p_rise_set) else $error("rise flag not set");

	property p_fall_set;
		@(posedge clock_i) disable iff (!resetn_i)
		(!state_q.sync2 && state_q.prev) |=> fall_edge_flag_o;
	endproperty
	a_fall_set: assert property (p_fall_set) else $error("fall flag not set");

	property p_rise_hold;
		@(posedge clock_i) disable iff (!resetn_i)
		(rise_edge_flag_o && !rise_flag_clr_i) |=> rise_edge_flag_o;
	endproperty
	a_rise_hold: assert property (p_rise_hold) else $error("rise flag lost");

	property p_fall_hold;
		@(posedge clock_i) disable iff (!resetn_i)
		(fall_edge_flag_o && !fall_flag_clr_i) |=> fall_edge_flag_o;
	endproperty
	a_fall_hold: assert property (p_fall_hold) else $error("fall flag lost");

	property p_sync_lag;
		@(posedge clock_i) disable iff (!resetn_i)
		##2 (synced_cmp_out_o == $past(raw_cmp_out_o, 2));
	endproperty
	a_sync_lag: assert property (p_sync_lag) else $error("sync delay wrong");

	property p_disabled_low;
		@(posedge clock_i) disable iff (!resetn_i)
		!cmp_enable_bit_i |-> !raw_cmp_out_o;
	endproperty
	a_disabled_low: assert property (p_disabled_low) else $error("output high while off");

	property p_irq_gate;
		@(posedge clock_i) disable iff (!resetn_i)
		irq_o |-> (cmp_src_irq_en_i && global_irq_en_i
			&& ((rise_edge_flag_o && rise_irq_en_i) || (fall_edge_flag_o && fall_irq_en_i)));
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("irq without cause");

	property p_pos_hyst;
		@(posedge clock_i) disable iff (!resetn_i)
		(cmp_enable_bit_i && !$past(raw_cmp_out_o) && raw_cmp_out_o)
			|-> (pos_ext > neg_ext);
	endproperty
	a_pos_hyst: assert property (p_pos_hyst) else $error("rose below threshold");

	property p_neg_hyst;
		@(posedge clock_i) disable iff (!resetn_i)
		(cmp_enable_bit_i && raw_cmp_out_o && neg_hyst_sel_i == CMPIRQ_HYST_MAX)
			|-> (pos_ext + (MV_W + 1)'(CMPIRQ_HYST_MV_MAX) > neg_ext);
	endproperty
	a_neg_hyst: assert property (p_neg_hyst) else $error("held high too low");

endmodule

// >>> src/cmpirq_pkg.sv
/*
 * Constants for the comparator output and edge interrupt block.
 * Assumes a single 100 MHz system clock; no register bus, all control is by ports.
 */
package cmpirq_pkg;
	// Hysteresis select codes (shared by positive and negative fields)
	localparam logic [1:0] CMPIRQ_HYST_OFF  = 2'h0;
	localparam logic [1:0] CMPIRQ_HYST_LVL1 = 2'h1;
	localparam logic [1:0] CMPIRQ_HYST_LVL2 = 2'h2;
	localparam logic [1:0] CMPIRQ_HYST_MAX  = 2'h3;
	// Hysteresis amounts in millivolts per code
	localparam int CMPIRQ_HYST_MV_OFF  = 0;
	localparam int CMPIRQ_HYST_MV_LVL1 = 5;
	localparam int CMPIRQ_HYST_MV_LVL2 = 10;
	localparam int CMPIRQ_HYST_MV_MAX  = 20;
	// Response mode codes
	localparam logic [1:0] CMPIRQ_MODE_FAST = 2'h0;
	localparam logic [1:0] CMPIRQ_MODE_1    = 2'h1;
	localparam logic [1:0] CMPIRQ_MODE_2    = 2'h2;
	localparam logic [1:0] CMPIRQ_MODE_SLOW = 2'h3;
	// Reset values
	localparam logic       CMPIRQ_RST_BIT   = 1'b0;
	// Voltage input width (millivolts, unsigned)
	localparam int CMPIRQ_MV_W = 16;
endpackage

// >>> sim/cmpirq_cpu.sv
/*
 * Processor side model: counts interrupt handler entries.
 * Assumes irq_i is a level request in the clock_i domain.
 */
`timescale 1ns/1ps
module cmpirq_cpu (
	// Clock and reset
	input  wire logic       clock_i,
	input  wire logic       resetn_i,
	// Request in, entry count out
	input  wire logic       irq_i,
	output logic      [7:0] entries_o
);
	logic irq_q;
	// A new request level means one more handler entry
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			irq_q     <= 1'b0;
			entries_o <= 8'h00;
		end else begin
			irq_q <= irq_i;
			if (irq_i && !irq_q) entries_o <= entries_o + 8'h01;
		end
	end
endmodule

// >>> sim/cmpirq_top_test.sv
/*
 * Self-checking bench for the comparator output block.
 * Assumes inputs settle 1 ns after each rising edge of a 100 MHz clock.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
	$display("unexpected %s exp %0h got %0h", nm, e, g); end end
module cmpirq_top_test;
	import cmpirq_pkg::*;
	logic        clock_i, resetn_i, en, rie, fie, rclr, fclr, src, glb;
	logic [1:0]  hp, hn, md;
	logic [15:0] pos, neg;
	wire         raw, syn, sts, rf, ff, irq, sdn;
	wire  [1:0]  am;
	wire  [7:0]  ent;
	int          failures, n_checks;
	int          mv[4] = '{CMPIRQ_HYST_MV_OFF, CMPIRQ_HYST_MV_LVL1,
		CMPIRQ_HYST_MV_LVL2, CMPIRQ_HYST_MV_MAX};
	cmpirq_top dut_u (.clock_i(clock_i), .resetn_i(resetn_i), .cmp_pos_input_i(pos),
		.cmp_neg_input_i(neg), .cmp_enable_bit_i(en), .pos_hyst_sel_i(hp),
		.neg_hyst_sel_i(hn), .response_mode_sel_i(md), .rise_irq_en_i(rie),
		.fall_irq_en_i(fie), .rise_flag_clr_i(rclr), .fall_flag_clr_i(fclr),
		.cmp_src_irq_en_i(src), .global_irq_en_i(glb), .raw_cmp_out_o(raw),
		.synced_cmp_out_o(syn), .cmp_result_status_o(sts), .rise_edge_flag_o(rf),
		.fall_edge_flag_o(ff), .irq_o(irq), .shutdown_o(sdn), .analog_mode_o(am));
	cmpirq_cpu cpu_u (.clock_i(clock_i), .resetn_i(resetn_i), .irq_i(irq), .entries_o(ent));
	////////////////////////////////////////////////////////////////////////////////
	// Wait n edges, then step past them
	task step(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask
	// Verdict and end of run
	task close_out;
		if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// Free running clock
	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end
	// Watchdog against a hang
	initial begin
		#5000;
		failures++;
		close_out();
	end
	// Test sequence
	initial begin
		{resetn_i, en, rie, fie, rclr, fclr, src, glb, hp, hn, md} = '0;
		pos = 16'h07D0;
		neg = 16'h03E8;
		step(3);
		resetn_i = 1'b1;
		`CHK("raw_off", 1'b0, raw)
		`CHK("shutdown", 1'b1, sdn)
		en = 1'b1;
		#1 `CHK("raw_on", 1'b1, raw)
		`CHK("shut_on", 1'b0, sdn)
		step(1); `CHK("sync_early", 1'b0, syn)
		step(1); `CHK("sync", 1'b1, syn)
		`CHK("status", 1'b1, sts)
		`CHK("rise_early", 1'b0, rf)
		step(1); `CHK("rise", 1'b1, rf)
		`CHK("irq_masked", 1'b0, irq)
		step(4); `CHK("rise_held", 1'b1, rf)
		{rie, src, glb} = 3'h7;
		step(1); `CHK("irq_on", 1'b1, irq)
		`CHK("entries_one", 8'h01, ent)
		glb = 1'b0;
		step(1); `CHK("irq_glb", 1'b0, irq)
		{glb, rie, fie} = 3'h5;
		step(1); `CHK("irq_other", 1'b0, irq)
		rclr = 1'b1;
		step(1); rclr = 1'b0;
		`CHK("rise_clr", 1'b0, rf)
		for (int c = 0; c < 4; c++) begin
			hp = c[1:0];
			hn = 2'h3 - c[1:0];
			pos = 16'h0000; step(3); `CHK("hy_lo", 1'b0, raw)
			pos = 16'(1000 + mv[c]); step(3); `CHK("hy_p", 1'b0, raw)
			pos = pos + 16'h0001; step(3); `CHK("hy_p1", 1'b1, raw)
			pos = 16'(1001 - mv[3-c]); step(3); `CHK("hy_n", 1'b1, raw)
			pos = pos - 16'h0001; step(3); `CHK("hy_n1", 1'b0, raw)
		end
		`CHK("fall", 1'b1, ff)
		`CHK("entries", 8'h02, ent)
		{rclr, fclr} = 2'h3;
		step(1); {rclr, fclr} = 2'h0;
		`CHK("both_clr", 2'h0, {rf, ff})
		for (int m = 0; m < 4; m++) begin
			md = m[1:0];
			step(1); `CHK("mode", m[1:0], am)
		end
		pos = 16'h07D0; step(3);
		en = 1'b0;
		#1 `CHK("raw_dis", 1'b0, raw)
		`CHK("shut_dis", 1'b1, sdn)
		close_out();
	end
endmodule
